// ---- scpag_top.sv ----
// Purpose: stack pointer with limit checks, program space address builder
// Assumes: single clock, core issues at most one stack op per cycle
// Notes:   register port answers reads one cycle later, never stalls
//
// Function
// [R1] stack pointer holds next free word, stack grows upward
// [R2] pop predecrements before read, push writes then post-increments
// [R3] call push clears the top byte of pushed program counter
// [R4] exception push puts status low byte in top byte
// [R5] limit and stack pointer bit 0 always read zero
// [R6] push/pop address, or else the stack-pointer effective address, compared with limit
// [R7] push at limit no trap, next push traps
// [R8] underflow trap when stack address below 0800h floor
// [R9] limit register not initialised by reset
// [R10] software avoids stack-indirect read right after limit write
// [R11] table address is table page above data effective address
// [R12] table page top bit selects user or configuration space
// [R13] visibility address from page register and ea low bits
// [R14] visibility remap forces program bit 23 to zero
// [R15] fetch address bit 23 zero, bits 22:1 from pc, bit 0 zero
// [R16] visibility ea bit 15 ignored, program bit 15 from page bit 0
// [R17] visibility page register holds only 00h or ffh
// [R18] table accesses byte-aligned, table reads allowed in config space
// [R19] visibility is read-only, low word only
// [R20] table access reaches every byte including upper byte
// [R21] table writes to configuration space refused
// [R22] visibility suspended while table operation in progress
// [R23] stack error is a single-cycle trap on the offending address
`timescale 1ns/100ps
`include "scpag_defs.svh"

module scpag_top (
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic [3:0]              i_reg_addr,
  input  wire logic [15:0]             i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output logic      [15:0]             o_reg_rdata,
  input  wire scpag_pkg::scpag_stk_req_t i_stk,
  input  wire logic [15:0]             i_sp_ea,
  input  wire logic                    i_sp_ea_valid,
  output logic      [15:0]             o_stk_addr,
  output logic      [15:0]             o_stk_wdata,
  output logic                         o_stk_err_trap,
  input  wire logic [22:0]             i_pc,
  input  wire scpag_pkg::scpag_tbl_req_t i_tbl,
  input  wire logic                    i_tbl_busy,
  input  wire logic [15:0]             i_data_ea,
  input  wire logic                    i_data_rd,
  input  wire logic                    i_data_wr,
  input  wire logic [7:0]              i_status_low_byte,
  output logic      [23:0]             o_fetch_addr,
  output scpag_pkg::scpag_paddr_t      o_tbl_paddr,
  output logic                         o_tbl_refused,
  output scpag_pkg::scpag_paddr_t      o_psv_paddr
);
  import scpag_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] stack_pointer_reg_r;
  logic [15:0] stack_pointer_reg_nxt;
  logic [15:0] stack_limit_r;
  logic [7:0]  table_page_select_r;
  logic [7:0]  visibility_page_select_r;
  logic        psv_en_r;
  logic        trap_r;
  logic        ovf_seen_r;
  logic        unf_seen_r;
  logic [15:0] rdata_r;
  logic [15:0] stk_addr_r;
  logic [15:0] stk_wdata_r;
  scpag_paddr_t tbl_paddr_r;
  scpag_paddr_t psv_paddr_r;
  logic        tbl_ref_r;
  logic [23:0] fetch_r;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_sp    = i_reg_wr && hit(i_reg_addr, `SCPAG_OFS_SP);
  wire wr_lim   = i_reg_wr && hit(i_reg_addr, `SCPAG_OFS_LIMIT);
  wire wr_tbl   = i_reg_wr && hit(i_reg_addr, `SCPAG_OFS_TBLPG);
  wire wr_psv   = i_reg_wr && hit(i_reg_addr, `SCPAG_OFS_PSVPG);
  wire wr_ctrl  = i_reg_wr && hit(i_reg_addr, `SCPAG_OFS_CTRL);
  wire wr_stat  = i_reg_wr && hit(i_reg_addr, `SCPAG_OFS_STATUS);

  // ------------------------------------------------------------
  // stack pointer and limit check
  // ------------------------------------------------------------
  // push address is current pointer, pop address is predecremented one
  wire [15:0] sp_dec  = stack_pointer_reg_r - `SCPAG_WORD_STEP;      // [R2]
  wire [15:0] sp_inc  = stack_pointer_reg_r + `SCPAG_WORD_STEP;      // [R1]
  wire [15:0] op_addr = i_stk.pop ? sp_dec : stack_pointer_reg_r;    // [R2]
  wire        stk_op  = i_stk.push || i_stk.pop;
  // other stack-pointer indirect addresses are checked in cycles with no push or pop
  wire        chk_v   = stk_op || i_sp_ea_valid;                     // [R6]
  wire [15:0] chk_a   = stk_op ? op_addr : i_sp_ea;                  // [R6]
  // a push at the limit is legal; only beyond it traps
  wire        ovf     = chk_v && (chk_a > stack_limit_r);            // [R7]
  wire        unf     = chk_v && (chk_a < `SCPAG_SP_FLOOR);          // [R8]
  // call pushes a cleared top byte, exceptions carry the status byte
  wire [15:0] push_d  = i_stk.exc ? {i_status_low_byte, i_stk.data[7:0]}
                                  : {8'h00, i_stk.data[7:0]};        // [R3] [R4]

  always_comb begin
    stack_pointer_reg_nxt = stack_pointer_reg_r;
    if (wr_sp) begin
      stack_pointer_reg_nxt = {i_reg_wdata[15:1], 1'b0};             // [R5]
    end else if (i_stk.push) begin
      stack_pointer_reg_nxt = sp_inc;                                // [R2]
    end else if (i_stk.pop) begin
      stack_pointer_reg_nxt = sp_dec;                                // [R2]
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stack_pointer_reg_r <= `SCPAG_SP_RESET;
      trap_r              <= 1'b0;
      ovf_seen_r          <= 1'b0;
      unf_seen_r          <= 1'b0;
      stk_addr_r          <= 16'h0000;
      stk_wdata_r         <= 16'h0000;
    end else begin
      stack_pointer_reg_r <= stack_pointer_reg_nxt;
      trap_r              <= ovf || unf;                             // [R23]
      // set wins over a software clear in the same cycle
      ovf_seen_r          <= ovf || (ovf_seen_r && !(wr_stat && i_reg_wdata[0]));
      unf_seen_r          <= unf || (unf_seen_r && !(wr_stat && i_reg_wdata[1]));
      stk_addr_r          <= op_addr;
      stk_wdata_r         <= push_d;
    end
  end

  // no reset: the limit holds whatever it powers up with
  always_ff @(posedge i_clk) begin
    if (wr_lim) begin
      stack_limit_r <= {i_reg_wdata[15:1], 1'b0};                    // [R9] [R5]
    end
  end

  // ------------------------------------------------------------
  // page registers and control
  // ------------------------------------------------------------
  // only the two supported pages are stored; any nonzero low byte written means eeprom
  wire [7:0] psv_wval = (i_reg_wdata[7:0] == `SCPAG_PSV_PROG) ? `SCPAG_PSV_PROG
                                                              : `SCPAG_PSV_EEPROM; // [R17]

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      table_page_select_r      <= 8'h00;
      visibility_page_select_r <= `SCPAG_PSV_PROG;
      psv_en_r                 <= 1'b0;
    end else begin
      if (wr_tbl) begin
        table_page_select_r <= i_reg_wdata[7:0];
      end
      if (wr_psv) begin
        visibility_page_select_r <= psv_wval;                        // [R17]
      end
      if (wr_ctrl) begin
        psv_en_r <= i_reg_wdata[`SCPAG_CTRL_PSVEN];
      end
    end
  end

  // ------------------------------------------------------------
  // program address generation
  // ------------------------------------------------------------
  wire        tbl_cfg  = table_page_select_r[`SCPAG_CFG_BIT];        // [R12]
  // full byte address kept, so the upper byte lane is reachable
  wire [23:0] tbl_addr = {table_page_select_r, i_tbl.ea};            // [R11] [R18] [R20]
  wire        tbl_ref  = i_tbl.valid && i_tbl.wr && tbl_cfg;         // [R21]
  // remap reads only, never during a table operation
  wire        psv_hit  = psv_en_r && i_data_ea[15] && i_data_rd && !i_data_wr
                         && !i_tbl_busy && !i_tbl.valid;             // [R19] [R22]
  wire [23:0] psv_addr = {1'b0, visibility_page_select_r, i_data_ea[14:1], 1'b0}; // [R13] [R14] [R16]

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tbl_paddr_r <= '0;
      psv_paddr_r <= '0;
      tbl_ref_r   <= 1'b0;
      fetch_r     <= 24'h000000;
    end else begin
      tbl_paddr_r <= '{addr: tbl_addr, cfg: tbl_cfg, wr: i_tbl.wr,
                       valid: i_tbl.valid && !tbl_ref};              // [R21]
      psv_paddr_r <= '{addr: psv_addr, cfg: 1'b0, wr: 1'b0, valid: psv_hit}; // [R14]
      tbl_ref_r   <= tbl_ref;
      fetch_r     <= {1'b0, i_pc[22:1], 1'b0};                       // [R15]
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    case (i_reg_addr)
      `SCPAG_OFS_SP:     rd_mux = stack_pointer_reg_r;
      `SCPAG_OFS_LIMIT:  rd_mux = {stack_limit_r[15:1], 1'b0};       // [R5]
      `SCPAG_OFS_TBLPG:  rd_mux = {8'h00, table_page_select_r};
      `SCPAG_OFS_PSVPG:  rd_mux = {8'h00, visibility_page_select_r};
      `SCPAG_OFS_CTRL:   rd_mux = {15'h0000, psv_en_r};
      `SCPAG_OFS_STATUS: rd_mux = {14'h0000, unf_seen_r, ovf_seen_r};
      default:           rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= i_reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign o_reg_rdata    = rdata_r;
  assign o_stk_addr     = stk_addr_r;
  assign o_stk_wdata    = stk_wdata_r;
  assign o_stk_err_trap = trap_r;
  assign o_fetch_addr   = fetch_r;
  assign o_tbl_paddr    = tbl_paddr_r;
  assign o_tbl_refused  = tbl_ref_r;
  assign o_psv_paddr    = psv_paddr_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_push_inc;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_stk.push && !wr_sp) |=> stack_pointer_reg_r == $past(stack_pointer_reg_r) + 16'h0002;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not post-increment"); // [R2]

  property p_pop_addr;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_stk.pop && !i_stk.push) |=> o_stk_addr == $past(stack_pointer_reg_r) - 16'h0002;
  endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop address not predecremented"); // [R2]

  property p_sp_even;
    @(posedge i_clk) disable iff (!i_resetn) stack_pointer_reg_r[0] == 1'b0;
  endproperty
  a_sp_even: assert property (p_sp_even) else $error("stack pointer odd"); // [R5]

  property p_call_msb;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_stk.push && !i_stk.exc) |=> o_stk_wdata[15:8] == 8'h00;
  endproperty
  a_call_msb: assert property (p_call_msb) else $error("call push top byte not clear"); // [R3]

  property p_exc_msb;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_stk.push && i_stk.exc) |=> o_stk_wdata[15:8] == $past(i_status_low_byte);
  endproperty
  a_exc_msb: assert property (p_exc_msb) else $error("exception push lacks status byte"); // [R4]

  sequence s_push_at_limit;
    i_stk.push && !i_stk.pop && stack_pointer_reg_r == stack_limit_r
      && stack_pointer_reg_r >= 16'h0800;
  endsequence
  property p_limit_push;
    @(posedge i_clk) disable iff (!i_resetn)
    s_push_at_limit |=> !o_stk_err_trap ##0 (i_stk.push && !wr_sp) |=> o_stk_err_trap;
  endproperty
  a_limit_push: assert property (p_limit_push) else $error("limit push trap wrong"); // [R7]

  property p_underflow;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_sp_ea_valid && !stk_op && i_sp_ea < 16'h0800) |=> o_stk_err_trap;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not trapped"); // [R8]

  property p_trap_cause;
    @(posedge i_clk) disable iff (!i_resetn)
    o_stk_err_trap |-> $past(chk_v);
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("trap without stack address"); // [R23] [R6]

  property p_tbl_addr;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_tbl.valid && !tbl_ref) |=> o_tbl_paddr.valid
      && o_tbl_paddr.addr == {$past(table_page_select_r), $past(i_tbl.ea)};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong"); // [R11]

  property p_cfg_wr;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_tbl.valid && i_tbl.wr && table_page_select_r[7]) |=> o_tbl_refused && !o_tbl_paddr.valid;
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config table write not refused"); // [R21] [R12]

  property p_psv_form;
    @(posedge i_clk) disable iff (!i_resetn)
    o_psv_paddr.valid |-> o_psv_paddr.addr[23] == 1'b0 && o_psv_paddr.addr[0] == 1'b0
      && o_psv_paddr.addr[15] == $past(visibility_page_select_r[0]);
  endproperty
  a_psv_form: assert property (p_psv_form) else $error("remap address malformed"); // [R14] [R16]

  property p_psv_susp;
    @(posedge i_clk) disable iff (!i_resetn) i_tbl_busy |=> !o_psv_paddr.valid;
  endproperty
  a_psv_susp: assert property (p_psv_susp) else $error("remap during table op"); // [R22]

  property p_fetch;
    @(posedge i_clk) disable iff (!i_resetn)
    1'b1 |=> o_fetch_addr == {1'b0, $past(i_pc[22:1]), 1'b0};
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong"); // [R15]

endmodule // scpag_top

// ---- scpag_defs.svh ----
// Purpose: constants for the stack check and program address generator
// Assumes: 100 MHz core clock, 16-bit data space, 24-bit program space
// Notes:   register offsets are on the plain register port
`ifndef SCPAG_DEFS_SVH
`define SCPAG_DEFS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SCPAG_OFS_SP      4'h0
`define SCPAG_OFS_LIMIT   4'h1
`define SCPAG_OFS_TBLPG   4'h2
`define SCPAG_OFS_PSVPG   4'h3
`define SCPAG_OFS_CTRL    4'h4
`define SCPAG_OFS_STATUS  4'h5

// ------------------------------------------------------------
// fields and values
// ------------------------------------------------------------
`define SCPAG_SP_RESET    16'h0800
`define SCPAG_SP_FLOOR    16'h0800
`define SCPAG_WORD_STEP   16'h0002
`define SCPAG_CFG_BIT     7
`define SCPAG_CTRL_PSVEN  0
`define SCPAG_PSV_PROG    8'h00
`define SCPAG_PSV_EEPROM  8'hff

`endif

// ---- scpag_pkg.sv ----
// Purpose: types for the stack check and program address generator
// Assumes: constants live in scpag_defs.svh
// Notes:   none
package scpag_pkg;

  typedef enum logic [1:0] {
    SCPAG_AC_FETCH,
    SCPAG_AC_TABLE,
    SCPAG_AC_PSV,
    SCPAG_AC_NONE
  } scpag_acc_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic        exc;
    logic [15:0] data;
  } scpag_stk_req_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [15:0] ea;
  } scpag_tbl_req_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        cfg;
    logic        wr;
    logic        valid;
  } scpag_paddr_t;

endpackage

// ---- scpag_core_model.sv ----
// Purpose: core-side model that turns bench stack commands into stack requests
// Assumes: at most one stack command per cycle
// Notes:   combinational, so the request lands on the edge the bench chose
`timescale 1ns/100ps

module scpag_core_model (
  input  wire logic [1:0]           i_op,
  input  wire logic [15:0]          i_data,
  output scpag_pkg::scpag_stk_req_t o_stk
);
  import scpag_pkg::*;

  // ------------------------------------------------------------
  // request encoding
  // ------------------------------------------------------------
  // op 1 call push, 2 exception push, 3 pop; push and pop never together
  assign o_stk.push = (i_op == 2'h1) || (i_op == 2'h2);
  assign o_stk.pop  = (i_op == 2'h3);
  assign o_stk.exc  = (i_op == 2'h2);
  assign o_stk.data = i_data;
  // stack-indirect checks are issued by the bench, never right after a limit write

endmodule // scpag_core_model

// ---- scpag_top_test.sv ----
// Purpose: self-checking bench for the stack check and program address generator
// Assumes: registered outputs one cycle after the request edge
// Notes:   seed fixed, random pages, addresses and data mixed with corner cases
`timescale 1ns/100ps
`include "scpag_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module scpag_top_test;
  import scpag_pkg::*;

  logic           clk, resetn, rwr, rrd, sp_ea_v, trap, tbusy, drd, dwr, tref, en;
  logic [3:0]     ra;
  logic [15:0]    wd, rdat, sp_ea, saddr, swdata, dea, od, sp_m, lim_m, r;
  logic [1:0]     op;
  logic [22:0]    pc;
  logic [7:0]     slb, tpg, ppg;
  logic [23:0]    faddr;
  scpag_stk_req_t stk;
  scpag_tbl_req_t tq;
  scpag_paddr_t   tpa, ppa;
  int             errors, n_tests;

  scpag_core_model scpag_core_model_inst (.i_op(op), .i_data(od), .o_stk(stk));

  scpag_top scpag_top_inst (
    .i_clk(clk), .i_resetn(resetn), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(rwr),
    .i_reg_rd(rrd), .o_reg_rdata(rdat), .i_stk(stk), .i_sp_ea(sp_ea),
    .i_sp_ea_valid(sp_ea_v), .o_stk_addr(saddr), .o_stk_wdata(swdata),
    .o_stk_err_trap(trap), .i_pc(pc), .i_tbl(tq), .i_tbl_busy(tbusy), .i_data_ea(dea),
    .i_data_rd(drd), .i_data_wr(dwr), .i_status_low_byte(slb), .o_fetch_addr(faddr),
    .o_tbl_paddr(tpa), .o_tbl_refused(tref), .o_psv_paddr(ppa)
  );

  // ------------------------------------------------------------
  // bus cycles and checks
  // ------------------------------------------------------------
  function automatic logic ovf(input logic [15:0] a);
    return (a > lim_m) || (a < `SCPAG_SP_FLOOR);
  endfunction

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    d = rdat;
  endtask

  task automatic stk_op(input logic [1:0] o, input logic [15:0] d);
    logic [15:0] ea;
    logic [15:0] ew;
    ea = (o == 2'h3) ? sp_m - 16'h0002 : sp_m;
    ew = {(o == 2'h2) ? slb : 8'h00, d[7:0]};
    @(posedge clk);
    op <= o;
    od <= d;
    @(posedge clk);
    op <= 2'h0;
    #1;
    `CHK("stk_addr", ea, saddr)
    if (o != 2'h3) `CHK("stk_wdata", ew, swdata)
    `CHK("stk_trap", ovf(ea), trap)
    sp_m = (o == 2'h3) ? ea : sp_m + 16'h0002;
    @(posedge clk);
    #1;
    `CHK("trap_len", 1'b0, trap)
  endtask

  task automatic ea_chk(input logic [15:0] a);
    @(posedge clk);
    sp_ea <= a;
    sp_ea_v <= 1'b1;
    @(posedge clk);
    sp_ea_v <= 1'b0;
    #1;
    `CHK("ea_trap", ovf(a), trap)
  endtask

  task automatic tbl_op(input logic w, input logic [15:0] a);
    logic rf;
    rf = w & tpg[7];
    @(posedge clk);
    tq <= '{1'b1, w, a};
    @(posedge clk);
    tq <= '0;
    #1;
    `CHK("tbl_refused", rf, tref)
    `CHK("tbl_valid", !rf, tpa.valid)
    if (!rf) `CHK("tbl_paddr", {tpg, a, tpg[7], w}, {tpa.addr, tpa.cfg, tpa.wr})
  endtask

  task automatic psv_op(input logic [15:0] a, input logic b, input logic w);
    logic v;
    v = a[15] & en & !b & !w;
    @(posedge clk);
    dea <= a;
    tbusy <= b;
    drd <= 1'b1;
    dwr <= w;
    @(posedge clk);
    drd <= 1'b0;
    dwr <= 1'b0;
    tbusy <= 1'b0;
    #1;
    `CHK("psv_valid", v, ppa.valid)
    if (v) `CHK("psv_paddr", {1'b0, ppg, a[14:1], 3'h0}, {ppa.addr, ppa.cfg, ppa.wr})
  endtask

  task automatic fetch(input logic [22:0] p);
    @(posedge clk);
    pc <= p;
    @(posedge clk);
    #1;
    `CHK("fetch", {1'b0, p[22:1], 1'b0}, faddr)
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run is a few hundred cycles, so 20000 means a hang
  initial begin
    #(20000 * 10);
    errors++;
    wrap_up;
  end

  initial begin
    {resetn, rwr, rrd, sp_ea_v, tbusy, drd, dwr, en} = '0;
    {ra, wd, sp_ea, dea, od, op, pc, slb, tq} = '0;
    {errors, n_tests} = '0;
    void'($urandom(32));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rreg(`SCPAG_OFS_SP, r);
    `CHK("sp_reset", `SCPAG_SP_RESET, r)
    rreg(`SCPAG_OFS_PSVPG, r);
    `CHK("psvpg_reset", 16'h0000, r)
    wreg(4'h6, 16'hffff);
    rreg(4'h6, r);
    `CHK("unmapped", 16'h0000, r)
    lim_m = 16'h0df4;
    wreg(`SCPAG_OFS_LIMIT, 16'h0df5); // limit has no reset value, so set it first
    rreg(`SCPAG_OFS_LIMIT, r);
    `CHK("limit_bit0", lim_m, r)
    wreg(`SCPAG_OFS_SP, 16'h0df5);
    rreg(`SCPAG_OFS_SP, r);
    `CHK("sp_bit0", lim_m, r)
    sp_m = lim_m;
    $display("test registers done");
    slb = 8'($urandom);
    stk_op(2'h1, 16'($urandom)); // at the limit, no trap
    stk_op(2'h2, 16'($urandom)); // one past, traps
    stk_op(2'h3, 16'h0000);
    ea_chk(lim_m);
    ea_chk(lim_m + 16'h0002);
    wreg(`SCPAG_OFS_SP, lim_m);
    @(posedge clk);
    op <= 2'h1;
    @(posedge clk);
    #1;
    `CHK("push_at_lim", 1'b0, trap)
    @(posedge clk);
    op <= 2'h0;
    #1;
    `CHK("push_past_lim", 1'b1, trap)
    wreg(`SCPAG_OFS_SP, 16'h0802);
    sp_m = 16'h0802;
    stk_op(2'h3, 16'h0000); // floor itself is legal
    stk_op(2'h3, 16'h0000); // below floor
    ea_chk(16'h07fe);
    rreg(`SCPAG_OFS_STATUS, r);
    `CHK("status", 16'h0003, r)
    wreg(`SCPAG_OFS_STATUS, 16'h0003);
    rreg(`SCPAG_OFS_STATUS, r);
    `CHK("status_clr", 16'h0000, r)
    $display("test stack done");
    tpg = 8'h80;
    wreg(`SCPAG_OFS_TBLPG, {8'h00, tpg});
    tbl_op(1'b0, 16'hffff);
    tbl_op(1'b1, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      tpg = 8'($urandom);
      wreg(`SCPAG_OFS_TBLPG, {8'h00, tpg});
      tbl_op(1'($urandom), 16'($urandom));
      fetch(23'($urandom));
    end
    $display("test table done");
    ppg = 8'h00;
    psv_op(16'h8002, 1'b0, 1'b0); // remap off
    wreg(`SCPAG_OFS_CTRL, 16'h0001);
    en = 1'b1;
    wreg(`SCPAG_OFS_PSVPG, 16'h005a);
    rreg(`SCPAG_OFS_PSVPG, r);
    `CHK("psvpg_ff", 16'h00ff, r)
    ppg = 8'hff;
    psv_op(16'hffff, 1'b1, 1'b0);
    psv_op(16'h8abc, 1'b0, 1'b1);
    psv_op(16'h7ffe, 1'b0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      ppg = i[0] ? 8'hff : 8'h00;
      wreg(`SCPAG_OFS_PSVPG, {8'h00, ppg});
      psv_op(16'($urandom), 1'b0, 1'b0);
    end
    $display("test remap done");
    wrap_up;
  end

endmodule // scpag_top_test
